// ### src/gc_gain_ctrl.sv
// Digital gain controller for the input amplifier/compressor, with APB slave
`timescale 1ns/1ps
`default_nettype none
module gc_gain_ctrl #(
  parameter int GAIN_W     = 7,
  parameter int HOLD_LONG  = gc_pkg::GC_HOLD_LONG,
  parameter int HOLD_SHORT = gc_pkg::GC_HOLD_SHRT
) (
  // Clock and reset
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  // APB slave
  input  wire gc_pkg::gc_apb_req_t apb_req,
  output var  gc_pkg::gc_apb_rsp_t apb_rsp,
  // Peak comparators
  input  wire logic               clip_above,
  input  wire logic               below_lower,
  // Amplifier gain code
  output logic [GAIN_W-1:0]       gain_code
);
  import gc_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (GAIN_W < 4 || GAIN_W > 7) $error("GAIN_W must be 4..7");
  if (HOLD_SHORT < 1 || HOLD_LONG < HOLD_SHORT || HOLD_LONG > 131071) $error("bad hold counts");

  localparam int HW = 17;
  localparam logic [HW-1:0] HOLD_L = HW'(HOLD_LONG);
  localparam logic [HW-1:0] HOLD_S = HW'(HOLD_SHORT);
  localparam logic [6:0]    DIV_M1 = 7'(GC_TICK_DIV - 1);

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic [7:0]        ctrl_reg, target_reg, fast_sel_reg, slow_sel_reg;
  logic [GAIN_W-1:0] fast_reg, slow_reg;
  logic [6:0]        div_reg;
  logic              tick_reg;
  logic [11:0]       tcnt_reg;
  logic [HW-1:0]     hold_reg;
  gc_apb_rsp_t       rsp_reg;

  gc_mode_t          mode;
  logic [GAIN_W-1:0] gmax;
  logic              auto_m, hold_done;
  logic              f_atk, f_rel, s_atk, s_rel;
  logic              wr_en, setup;
  logic [GAIN_W-1:0] gain_next;

  assign mode   = gc_mode_t'(ctrl_reg[GC_MODE_LSB +: 2]);
  assign gmax   = target_reg[GAIN_W-1:0];
  assign auto_m = (mode == GC_MODE_DUAL) || (mode == GC_MODE_SINGLE);
  assign setup  = apb_req.psel && !apb_req.penable;
  assign wr_en  = apb_req.psel && apb_req.penable && rsp_reg.pready && apb_req.pwrite;

  // ---------------------------------------------------------------------------
  // Gain clock: 1.280 MHz tick and rate strobes
  // ---------------------------------------------------------------------------
  // Divider; 125/1.28 is not whole, so the tick runs 0.4 % slow
  always_ff @(posedge clk_sys) begin
    if (sys_rst || div_reg == DIV_M1) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    tick_reg <= !sys_rst && (div_reg == DIV_M1);
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tcnt_reg <= 12'h000;
    end else if (tick_reg) begin
      tcnt_reg <= tcnt_reg + 12'h001;
    end
  end

  // Select 8, 32, 128 or 512 ticks per step; code 0 gives 80 kdB/s
  function automatic logic rate_hit(input logic [1:0] sel, input logic [11:0] t, input logic tk);
    logic [11:0] mask;
    mask = 12'((GC_STEP_TICKS << (2 * sel)) - 1);
    return tk && ((t & mask) == 12'h000);
  endfunction : rate_hit

  assign f_atk = rate_hit(fast_sel_reg[1:0], tcnt_reg, tick_reg);
  assign f_rel = rate_hit(fast_sel_reg[GC_REL_LSB +: 2], tcnt_reg, tick_reg);
  assign s_atk = rate_hit(slow_sel_reg[1:0], tcnt_reg, tick_reg);
  assign s_rel = rate_hit(slow_sel_reg[GC_REL_LSB +: 2], tcnt_reg, tick_reg);

  // ---------------------------------------------------------------------------
  // Release hold timer
  // ---------------------------------------------------------------------------
  // Restarts whenever the signal climbs back over the lower threshold
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !below_lower) begin
      hold_reg <= '0;
    end else if (tick_reg && !hold_done) begin
      hold_reg <= hold_reg + HW'(1);
    end
  end

  assign hold_done = hold_reg >= (ctrl_reg[GC_HOLD_BIT] ? HOLD_S : HOLD_L);

  // ---------------------------------------------------------------------------
  // Fast counter
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      fast_reg <= GC_TARGET_RST[GAIN_W-1:0];
    end else begin
      case (mode)
        GC_MODE_DUAL, GC_MODE_SINGLE: begin
          if (fast_reg > gmax) begin
            fast_reg <= gmax;
          end else if (clip_above) begin
            if (f_atk && fast_reg != '0) begin
              fast_reg <= fast_reg - 1'b1;
            end
          end else if (below_lower && hold_done && f_rel && fast_reg < gmax) begin
            fast_reg <= fast_reg + 1'b1;
          end
        end
        GC_MODE_STEP: begin
          if (fast_reg > gmax && f_atk) begin
            fast_reg <= fast_reg - 1'b1;
          end else if (fast_reg < gmax && f_rel) begin
            fast_reg <= fast_reg + 1'b1;
          end
        end
        GC_MODE_IMM: fast_reg <= gmax;
        default:     fast_reg <= gmax;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Slow counter
  // ---------------------------------------------------------------------------
  // Outside dual mode it is parked on the fast value so a return is seamless
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      slow_reg <= GC_TARGET_RST[GAIN_W-1:0];
    end else if (mode != GC_MODE_DUAL) begin
      slow_reg <= fast_reg;
    end else if (slow_reg > fast_reg && s_atk) begin
      slow_reg <= slow_reg - 1'b1;
    end else if (slow_reg < fast_reg && s_rel) begin
      slow_reg <= slow_reg + 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Applied gain
  // ---------------------------------------------------------------------------
  always_comb begin
    gain_next = fast_reg;
    if (mode == GC_MODE_DUAL && slow_reg < fast_reg) begin
      gain_next = slow_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gain_code <= GC_TARGET_RST[GAIN_W-1:0];
    end else begin
      gain_code <= gain_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_reg     <= GC_CTRL_RST;
      target_reg   <= GC_TARGET_RST;
      fast_sel_reg <= GC_RATE_RST;
      slow_sel_reg <= GC_RATE_RST;
    end else if (wr_en) begin
      case (apb_req.paddr)
        GC_OFF_CTRL:   ctrl_reg     <= apb_req.pwdata[7:0] & 8'h1c;
        GC_OFF_TARGET: target_reg   <= apb_req.pwdata[7:0] & (8'h80 | 8'((1 << GAIN_W) - 1));
        GC_OFF_FAST:   fast_sel_reg <= apb_req.pwdata[7:0] & 8'h0f;
        GC_OFF_SLOW:   slow_sel_reg <= apb_req.pwdata[7:0] & 8'h0f;
        default:       ;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // APB answer: data prepared in setup, pready high in the first access cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rsp_reg <= '0;
    end else begin
      rsp_reg.pready  <= setup;
      rsp_reg.pslverr <= 1'b0;
      rsp_reg.prdata  <= 32'h0000_0000;
      if (setup) begin
        case (apb_req.paddr)
          GC_OFF_CTRL:   rsp_reg.prdata[7:0] <= ctrl_reg;
          GC_OFF_TARGET: rsp_reg.prdata[7:0] <= target_reg[GC_RDMODE_BIT] ? 8'(gain_next) : target_reg;
          GC_OFF_FAST:   rsp_reg.prdata[7:0] <= fast_sel_reg;
          GC_OFF_SLOW:   rsp_reg.prdata[7:0] <= slow_sel_reg;
          GC_OFF_STAT: begin
            rsp_reg.prdata[7:0]                <= 8'(gain_next);
            rsp_reg.prdata[GC_STAT_SLOW +: 8]  <= 8'(slow_reg);
            rsp_reg.prdata[GC_STAT_FAST +: 8]  <= 8'(fast_reg);
          end
          default:       rsp_reg.pslverr <= 1'b1;
        endcase
      end
    end
  end

  assign apb_rsp = rsp_reg;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence apb_setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence apb_access_s;
    apb_req.psel && apb_req.penable;
  endsequence

  apb_ready_a: assert property (apb_setup_s ##1 apb_access_s |-> apb_rsp.pready)
    else $error("pready missing in first access cycle");
  mode_reset_a: assert property ($fell(sys_rst) |-> mode == GC_MODE_DUAL)
    else $error("mode not dual after reset");
  tick_spacing_a: assert property (tick_reg |=> !tick_reg [*8])
    else $error("gain tick too frequent");
  attack_step_a: assert property (auto_m && clip_above && f_atk && fast_reg != '0
                                  && fast_reg <= gmax |=> fast_reg == $past(fast_reg) - 1'b1)
    else $error("attack step missing");
  hold_block_a: assert property (auto_m && !clip_above && !hold_done && fast_reg <= gmax
                                 |=> fast_reg <= $past(fast_reg))
    else $error("gain rose before hold expired");
  max_limit_a: assert property (auto_m && fast_reg <= gmax && !wr_en |=> fast_reg <= gmax)
    else $error("gain above maximum");
  dual_min_a: assert property (mode == GC_MODE_DUAL |=> gain_code ==
                               ($past(slow_reg) < $past(fast_reg) ? $past(slow_reg) : $past(fast_reg)))
    else $error("dual gain not the minimum");
  single_gain_a: assert property (mode == GC_MODE_SINGLE |=> gain_code == $past(fast_reg))
    else $error("single gain not from fast counter");
  step_slew_a: assert property (mode == GC_MODE_STEP && $past(mode) == GC_MODE_STEP
                                |-> fast_reg - $past(fast_reg) inside {'0, '1, GAIN_W'(1)})
    else $error("stepped mode skipped a step");
  imm_jump_a: assert property (mode == GC_MODE_IMM |=> fast_reg == $past(gmax))
    else $error("immediate mode did not jump");
  slow_track_a: assert property (mode == GC_MODE_DUAL && $past(mode) == GC_MODE_DUAL
                                 && $past(slow_reg) < $past(fast_reg) |-> slow_reg >= $past(slow_reg))
    else $error("slow counter moved away from fast");
endmodule : gc_gain_ctrl
`default_nettype wire

// ### src/gc_pkg.sv
// Package: register map, field layout, timing constants for the gain controller
`default_nettype none
package gc_pkg;
  // ---------------------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] GC_OFF_CTRL   = 8'h00; // compressor_control_reg
  localparam logic [7:0] GC_OFF_TARGET = 8'h04; // gain_target_reg
  localparam logic [7:0] GC_OFF_FAST   = 8'h08; // fast_rate_select_reg
  localparam logic [7:0] GC_OFF_SLOW   = 8'h0c; // secondary_rate_config_reg
  localparam logic [7:0] GC_OFF_STAT   = 8'h10; // live counters, read only
  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int         GC_MODE_LSB    = 2;
  localparam int         GC_HOLD_BIT    = 4;
  localparam int         GC_RDMODE_BIT  = 7;
  localparam int         GC_REL_LSB     = 2;
  localparam int         GC_STAT_SLOW   = 8;
  localparam int         GC_STAT_FAST   = 16;
  localparam logic [7:0] GC_CTRL_RST    = 8'h00;
  localparam logic [7:0] GC_TARGET_RST  = 8'h50;
  localparam logic [7:0] GC_RATE_RST    = 8'h00;
  // ---------------------------------------------------------------------------
  // Timing: 1.280 MHz gain clock derived from 125 MHz system clock
  // ---------------------------------------------------------------------------
  localparam int GC_SYS_HZ       = 125000000;
  localparam int GC_GAIN_HZ      = 1280000;
  localparam int GC_TICK_DIV     = (GC_SYS_HZ + GC_GAIN_HZ / 2) / GC_GAIN_HZ;
  localparam int GC_HOLD_LONG_MS = 50;
  localparam int GC_HOLD_SHRT_MS = 25;
  localparam int GC_HOLD_LONG    = GC_HOLD_LONG_MS * (GC_GAIN_HZ / 1000);
  localparam int GC_HOLD_SHRT    = GC_HOLD_SHRT_MS * (GC_GAIN_HZ / 1000);
  localparam int GC_STEP_MDB     = 500;   // one gain step, millidecibel
  localparam int GC_FIX_DBPS     = 80000; // slew at rate-select code 0, dB per second
  localparam int GC_STEP_TICKS   = GC_GAIN_HZ / (GC_FIX_DBPS * 1000 / GC_STEP_MDB);
  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    GC_MODE_DUAL   = 2'b00,
    GC_MODE_SINGLE = 2'b01,
    GC_MODE_STEP   = 2'b10,
    GC_MODE_IMM    = 2'b11
  } gc_mode_t;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } gc_apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } gc_apb_rsp_t;
endpackage : gc_pkg
`default_nettype wire

// ### dv/gc_amp_model.sv
// Behavioural model of the amplifier output level and its two peak comparators
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------------------
// Amplifier and comparators
// ---------------------------------------------------------------------------
module gc_amp_model #(
  parameter int UPPER = 100, // Clip level in 0.5 dB units
  parameter int BAND  = 6    // 3 dB hysteresis gap, 0.5 dB per step
) (
  // Clock
  input  wire logic       clk_sys,
  // Input amplitude and applied gain, both in 0.5 dB units
  input  wire logic [7:0] amp,
  input  wire logic [6:0] gain_code,
  // Comparator results
  output logic            clip_above  = 1'b0,
  output logic            below_lower = 1'b0
);
  // Registered detectors: the level only changes after a clock edge, as a real
  // comparator latch would, so the controller never sees a same-edge race
  always @(posedge clk_sys) begin
    clip_above  <= (int'(amp) + int'(gain_code)) > UPPER;
    below_lower <= (int'(amp) + int'(gain_code)) < UPPER - BAND;
  end
endmodule : gc_amp_model
`default_nettype wire

// ### dv/compressor_gain_controller_tb.sv
// Testbench: register access and gain loop scenarios for the gain controller
`timescale 1ns/1ps
`default_nettype none
module compressor_gain_controller_tb;
  import gc_pkg::*;
  // ---------------------------------------------------------------------------
  // Setup
  // ---------------------------------------------------------------------------
  localparam int HL   = 40;              // Shortened long hold, ticks
  localparam int HS   = 20;              // Shortened short hold, ticks
  localparam int STEP = 8 * GC_TICK_DIV; // Clocks per fastest gain step
  logic        clk_sys   = 1'b0;
  logic        sys_rst   = 1'b1;
  gc_apb_req_t apb_req   = '0;
  gc_apb_rsp_t apb_rsp;
  logic        clip_above;
  logic        below_lower;
  logic [6:0]  gain_code;
  logic [6:0]  prev_gain = 7'h00;
  logic [7:0]  amp       = 8'h00;
  logic        watch     = 1'b0;
  logic [31:0] rd;
  logic        er;
  int          num_errors      = 0;
  int          samples_checked = 0;

  always #4 clk_sys = ~clk_sys;

  gc_gain_ctrl #(.GAIN_W(7), .HOLD_LONG(HL), .HOLD_SHORT(HS)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .clip_above(clip_above), .below_lower(below_lower), .gain_code(gain_code));
  gc_amp_model #(.UPPER(100), .BAND(6)) amp_i (
    .clk_sys(clk_sys), .amp(amp), .gain_code(gain_code),
    .clip_above(clip_above), .below_lower(below_lower));

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    @(posedge clk_sys);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clk_sys);
    apb_req.penable <= 1'b1;
    // No assumed latency: only the watchdog ends this wait
    do begin
      @(posedge clk_sys);
    end while (apb_rsp.pready !== 1'b1);
    rdat = apb_rsp.prdata;
    err  = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(1'b1, a, d, x, e);
  endtask : wr

  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    check(nm, rd, exp);
  endtask : rc

  // Bounded wait for a gain code, then compare
  task automatic wait_gain(input logic [6:0] v, input int lim);
    int n;
    n = 0;
    while (gain_code !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check("gain", {25'h0, gain_code}, {25'h0, v});
  endtask : wait_gain

  task results;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Stepped slew must pass every code; a jump shows as a larger difference
  always @(posedge clk_sys) begin
    if (watch && gain_code !== prev_gain) check("step size", {25'h0, 7'(prev_gain - gain_code)}, 32'h1);
    prev_gain <= gain_code;
  end

  // Hang guard, sized well beyond the longest expected run
  initial begin
    repeat (90000) @(posedge clk_sys);
    num_errors++;
    results();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rc("ctrl", GC_OFF_CTRL, 32'h0);
    rc("target", GC_OFF_TARGET, 32'h50);
    rc("fast", GC_OFF_FAST, 32'h0);
    rc("slow", GC_OFF_SLOW, 32'h0);
    rc("status", GC_OFF_STAT, 32'h505050);
    apb(1'b0, 8'h14, 32'h0, rd, er);
    check("unmapped", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // Immediate mode with a loud input: comparators must be ignored
    amp <= 8'h5a;
    wr(GC_OFF_CTRL, 32'h0c);
    rc("mode", GC_OFF_CTRL, 32'h0c);
    wr(GC_OFF_TARGET, 32'h31);
    wait_gain(7'h31, 4);
    rc("stored", GC_OFF_TARGET, 32'h31);
    // Stepped mode, live readback while slewing down
    wr(GC_OFF_CTRL, 32'h08);
    watch <= 1'b1;
    wr(GC_OFF_TARGET, 32'ha8);
    rc("live", GC_OFF_TARGET, 32'h31);
    repeat (6 * STEP) @(posedge clk_sys);
    check("no jump", {31'h0, gain_code > 7'h29}, 32'h1);
    wait_gain(7'h28, 4 * STEP);
    watch <= 1'b0;
    // Single-rate automatic, short hold, quiet input
    amp <= 8'h00;
    wr(GC_OFF_TARGET, 32'h40);
    wr(GC_OFF_CTRL, 32'h14);
    repeat (HS * GC_TICK_DIV - 200) @(posedge clk_sys);
    check("hold", {25'h0, gain_code}, 32'h28);
    wait_gain(7'h40, 26 * STEP);
    repeat (4 * STEP) @(posedge clk_sys);
    check("max", {25'h0, gain_code}, 32'h40);
    rc("copy", GC_OFF_STAT, 32'h404040);
    // Loud input attacks down to the clip edge
    amp <= 8'h32;
    wait_gain(7'h32, 16 * STEP);
    // Dual-rate, slowest secondary pair: slow counter stays at 0x32 while fast climbs
    wr(GC_OFF_SLOW, 32'h0f);
    wr(GC_OFF_CTRL, 32'h00);
    amp <= 8'h28;
    repeat (HL * GC_TICK_DIV + 3 * STEP) @(posedge clk_sys);
    apb(1'b0, GC_OFF_STAT, 32'h0, rd, er);
    check("min", {16'h0, rd[15:0]}, 32'h3232);
    check("fast ahead", {31'h0, rd[23:16] > 8'h32}, 32'h1);
    // Faster secondary pair; applied gain is the lagging slow value, so fast runs to max
    repeat (STEP) @(posedge clk_sys);
    wr(GC_OFF_SLOW, 32'h05);
    repeat (20000) @(posedge clk_sys);
    rc("track", GC_OFF_STAT, 32'h403838);
    rc("slow rates", GC_OFF_SLOW, 32'h05);
    wr(GC_OFF_FAST, 32'hff);
    rc("fast mask", GC_OFF_FAST, 32'h0f);
    results();
  end
endmodule : compressor_gain_controller_tb
`default_nettype wire
